/* inc/atc_pkg.sv */
// Function
// - the sampling timer runs alone in normal counting mode, never synchronised with other channels.
// - the sampling timer counter clears to zero when it matches the period register.
// - period and compare-A registers are loaded with 128, a 129-tick cycle of 33.024 us at 250 MHz.
// - compare registers C to F hold 104 (26.624 us at 250 MHz) and their matches drive no pin and no interrupt.
// - the four timer pins keep their outputs disabled.
// - every compare-A match pulses the conversion start trigger and raises the compare-A interrupt.
// - compare interrupts B to F stay disabled and are never raised.
// - the sampling timer raises no overflow interrupt.
// - the edge counter counts both edges of the external count input.
// - the edge counter compare-A register holds 128.
// - the edge counter raises its compare-A interrupt on each compare-A match.
// - edge counter compare-B holds 10, raises no interrupt, and its output pin stays unused.
// - the edge counter raises an overflow interrupt when it rolls past 255.
package atc_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_MASK    = 8'h08;
  localparam logic [7:0] ADDR_PERIOD  = 8'h0C;
  localparam logic [7:0] ADDR_CMPA    = 8'h10;
  localparam logic [7:0] ADDR_CMPC    = 8'h14;
  localparam logic [7:0] ADDR_ECMPA   = 8'h18;
  localparam logic [7:0] ADDR_ECMPB   = 8'h1C;
  localparam logic [7:0] ADDR_COUNT   = 8'h20;
  localparam logic [7:0] ADDR_PRIO    = 8'h24;

  // ****************************************************
  // status bit positions
  // ****************************************************
  localparam int ST_SAMP_A  = 0;
  localparam int ST_EDGE_A  = 1;
  localparam int ST_EDGE_OV = 2;
  localparam int ST_W       = 3;

  // ****************************************************
  // reset values and timing
  // ****************************************************
  localparam logic [15:0] PERIOD_RST  = 16'h0080;
  localparam logic [15:0] CMPA_RST    = 16'h0080;
  localparam logic [15:0] CMPCF_RST   = 16'h0068;
  localparam logic [7:0]  ECMPA_RST   = 8'h80;
  localparam logic [7:0]  ECMPB_RST   = 8'h0A;
  localparam logic [1:0]  CTRL_RST    = 2'h3;
  localparam logic [ST_W-1:0] MASK_RST = 3'h7;
  localparam int          PRESCALE    = 64;
  localparam int          CLK_MHZ     = 250;
  localparam int          CYCLE_US    = 125;
  localparam int          CMPCF_US    = 100;
  localparam logic [3:0]  PRIO_SAMP   = 4'hF;
  localparam logic [3:0]  PRIO_EDGE   = 4'hA;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic samp_a;
    logic edge_a;
    logic edge_ov;
  } atc_evt_t;

  typedef struct packed {
    logic [3:0] oe_n;
    logic [3:0] o;
  } atc_pins_t;

endpackage

/* rtl/atc_edge_counter.sv */
`timescale 1ns/1ns
module atc_edge_counter
  import atc_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // control
  input  wire logic         enable,
  input  wire logic         pin_sync,
  input  wire logic [W-1:0] cmp_a,
  input  wire logic [W-1:0] cmp_b,
  // state and events
  output logic      [W-1:0] count,
  output logic              match_a,
  output logic              match_b,
  output logic              ovf
);

  logic         prev_r, prev_nxt;
  logic [W-1:0] cnt_r, cnt_nxt;
  logic         ma_r, ma_nxt, mb_r, mb_nxt, ov_r, ov_nxt;
  logic         edge_seen;

  // count on both edges, free running
  always_comb begin
    edge_seen = enable && (pin_sync != prev_r);
    prev_nxt  = pin_sync;
    cnt_nxt   = cnt_r;
    ma_nxt    = 1'b0;
    mb_nxt    = 1'b0;
    ov_nxt    = 1'b0;
    if (edge_seen) begin
      cnt_nxt = cnt_r + 1'b1;
      ov_nxt  = &cnt_r;
      ma_nxt  = (cnt_nxt == cmp_a);
      mb_nxt  = (cnt_nxt == cmp_b);
    end
  end

  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
      cnt_r  <= '0;
      ma_r   <= 1'b0;
      mb_r   <= 1'b0;
      ov_r   <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      cnt_r  <= cnt_nxt;
      ma_r   <= ma_nxt;
      mb_r   <= mb_nxt;
      ov_r   <= ov_nxt;
    end
  end

  assign count   = cnt_r;
  assign match_a = ma_r;
  assign match_b = mb_r;
  assign ovf     = ov_r;

  // ****************************************************
  // checks
  // ****************************************************
  a_edge_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    ov_r |-> cnt_r == '0) else $error("overflow without wrap to zero");
  a_edge_step: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(edge_seen) |-> cnt_r == $past(cnt_r) + 1'b1)
    else $error("edge not counted");
  a_edge_nclr: assert property (@(posedge aclk) disable iff (!aresetn)
    ma_r |=> cnt_r == $past(cnt_r) || cnt_r == $past(cnt_r) + 1'b1)
    else $error("counter cleared on match");

endmodule

/* rtl/atc_top.sv */
`timescale 1ns/1ns
module atc_top
  import atc_pkg::*;
#(
  parameter int TW = 16,
  parameter int EW = 8
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  // axi4-lite write response
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  // axi4-lite read data
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // external count input pin
  input  wire logic        external_count_input,
  // converter trigger and interrupts
  output logic             conversion_start_trigger,
  output logic             compare_a_irq,
  output logic             counter_match_a_irq,
  output logic             counter_overflow_irq,
  output logic             irq,
  // timer pins, outputs disabled
  output atc_pins_t        timer_pins,
  output logic             counter_output_pin,
  output logic             counter_output_pin_oe_n
);

  localparam int PDIV      = PRESCALE;
  localparam int CYC_TICKS = CYCLE_US * CLK_MHZ;

  // ****************************************************
  // input synchroniser
  // ****************************************************
  logic sync1_r, sync2_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= external_count_input;
      sync2_r <= sync1_r;
    end
  end

  // ****************************************************
  // register state
  // ****************************************************
  logic [1:0]      ctrl_r, ctrl_nxt;
  logic [ST_W-1:0] stat_r, stat_nxt;
  logic [ST_W-1:0] mask_r, mask_nxt;
  logic [TW-1:0]   period_r, period_nxt;
  logic [TW-1:0]   cmpa_r, cmpa_nxt;
  logic [TW-1:0]   cmpcf_r, cmpcf_nxt;
  logic [EW-1:0]   ecmpa_r, ecmpa_nxt;
  logic [EW-1:0]   ecmpb_r, ecmpb_nxt;

  // ****************************************************
  // bus handshake state
  // ****************************************************
  logic       aw_has_r, aw_has_nxt, w_has_r, w_has_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic       bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic       do_write;

  // ****************************************************
  // sampling timer state
  // ****************************************************
  logic [5:0]    div_r, div_nxt;
  logic          tick_r, tick_nxt;
  logic [TW-1:0] counter_value_r, counter_value_nxt;
  logic          trig_r, trig_nxt;
  logic          cmpc_hit;

  // ****************************************************
  // edge counter and events
  // ****************************************************
  logic [EW-1:0] ecount;
  logic          e_ma, e_mb, e_ov;
  atc_evt_t      evt;
  logic          irq_r, irq_nxt;
  logic          cma_r, cma_nxt, eov_r, eov_nxt, sir_r, sir_nxt;

  atc_edge_counter #(.W(EW)) u_edge (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .enable   (ctrl_r[1]),
    .pin_sync (sync2_r),
    .cmp_a    (ecmpa_r),
    .cmp_b    (ecmpb_r),
    .count    (ecount),
    .match_a  (e_ma),
    .match_b  (e_mb),
    .ovf      (e_ov)
  );

  // merge a byte-laned write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  // decode of mapped addresses, shared by read and write
  function automatic logic mapped(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_MASK ||
           a == ADDR_PERIOD || a == ADDR_CMPA || a == ADDR_CMPC ||
           a == ADDR_ECMPA || a == ADDR_ECMPB || a == ADDR_COUNT ||
           a == ADDR_PRIO;
  endfunction

  // sampling timer: divide by 64, count on falling edge of slow clock
  always_comb begin
    div_nxt  = ctrl_r[0] ? 6'(div_r + 1'b1) : 6'h00;
    tick_nxt = ctrl_r[0] && (div_r == 6'(PDIV - 1));
    counter_value_nxt = counter_value_r;
    trig_nxt = 1'b0;
    if (tick_r) begin
      if (counter_value_r == period_r) counter_value_nxt = '0;
      else counter_value_nxt = counter_value_r + 1'b1;
      trig_nxt = (counter_value_r == cmpa_r);
    end
  end
  // compare C..F matches go nowhere but the compare-C register readback
  assign cmpc_hit = (counter_value_r == cmpcf_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r  <= 6'h00;
      tick_r <= 1'b0;
      counter_value_r <= '0;
      trig_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
      counter_value_r <= counter_value_nxt;
      trig_r <= trig_nxt;
    end
  end

  // bus slave: capture aw/w in any order, respond once both held
  assign do_write = aw_has_r && w_has_r && !bvalid_r;
  always_comb begin
    aw_has_nxt  = aw_has_r;
    aw_addr_nxt = aw_addr_r;
    w_has_nxt   = w_has_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (s_awvalid && !aw_has_r) begin
      aw_has_nxt  = 1'b1;
      aw_addr_nxt = s_awaddr;
    end
    if (s_wvalid && !w_has_r) begin
      w_has_nxt  = 1'b1;
      w_data_nxt = s_wdata;
      w_strb_nxt = s_wstrb;
    end
    if (do_write) begin
      aw_has_nxt = 1'b0;
      w_has_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = mapped(aw_addr_r) ? 2'h0 : 2'h2;
    end
    if (bvalid_r && s_bready) bvalid_nxt = 1'b0;
    if (s_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = mapped(s_araddr) ? 2'h0 : 2'h2;
      unique case (s_araddr)
        ADDR_CTRL:   rdata_nxt = 32'(ctrl_r);
        ADDR_STATUS: rdata_nxt = 32'(stat_r);
        ADDR_MASK:   rdata_nxt = 32'(mask_r);
        ADDR_PERIOD: rdata_nxt = 32'(period_r);
        ADDR_CMPA:   rdata_nxt = 32'(cmpa_r);
        ADDR_CMPC:   rdata_nxt = {15'h0000, cmpc_hit, cmpcf_r};
        ADDR_ECMPA:  rdata_nxt = 32'(ecmpa_r);
        ADDR_ECMPB:  rdata_nxt = {23'h000000, e_mb, ecmpb_r};
        ADDR_COUNT:  rdata_nxt = {8'h00, ecount, counter_value_r};
        ADDR_PRIO:   rdata_nxt = {24'h000000, PRIO_EDGE, PRIO_SAMP};
        default:     rdata_nxt = 32'h0000_0000;
      endcase
    end else if (rvalid_r && s_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // register file: writes, sticky status with set over clear
  always_comb begin
    logic [31:0] m;
    m          = merge(32'h0000_0000, w_data_r, w_strb_r);
    ctrl_nxt   = ctrl_r;
    mask_nxt   = mask_r;
    period_nxt = period_r;
    cmpa_nxt   = cmpa_r;
    cmpcf_nxt  = cmpcf_r;
    ecmpa_nxt  = ecmpa_r;
    ecmpb_nxt  = ecmpb_r;
    stat_nxt   = stat_r;
    if (do_write) begin
      unique case (aw_addr_r)
        ADDR_CTRL:   ctrl_nxt = 2'(merge(32'(ctrl_r), w_data_r, w_strb_r));
        ADDR_STATUS: stat_nxt = stat_r & ~m[ST_W-1:0];
        ADDR_MASK:   mask_nxt = ST_W'(merge(32'(mask_r), w_data_r, w_strb_r));
        ADDR_PERIOD: period_nxt = TW'(merge(32'(period_r), w_data_r,
                                            w_strb_r));
        ADDR_CMPA:   cmpa_nxt = TW'(merge(32'(cmpa_r), w_data_r, w_strb_r));
        ADDR_CMPC:   cmpcf_nxt = TW'(merge(32'(cmpcf_r), w_data_r, w_strb_r));
        ADDR_ECMPA:  ecmpa_nxt = EW'(merge(32'(ecmpa_r), w_data_r, w_strb_r));
        ADDR_ECMPB:  ecmpb_nxt = EW'(merge(32'(ecmpb_r), w_data_r, w_strb_r));
        default:     ;
      endcase
    end
    // only compare-A and edge A/overflow events set status (B..F none)
    evt.samp_a  = trig_r;
    evt.edge_a  = e_ma;
    evt.edge_ov = e_ov;
    stat_nxt    = stat_nxt | ST_W'({evt.edge_ov, evt.edge_a, evt.samp_a});
    irq_nxt     = |(stat_nxt & mask_nxt);
    sir_nxt     = stat_nxt[ST_SAMP_A] & mask_nxt[ST_SAMP_A];
    cma_nxt     = stat_nxt[ST_EDGE_A] & mask_nxt[ST_EDGE_A];
    eov_nxt     = stat_nxt[ST_EDGE_OV] & mask_nxt[ST_EDGE_OV];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r    <= CTRL_RST;
      stat_r    <= '0;
      mask_r    <= MASK_RST;
      period_r  <= PERIOD_RST;
      cmpa_r    <= CMPA_RST;
      cmpcf_r   <= CMPCF_RST;
      ecmpa_r   <= ECMPA_RST;
      ecmpb_r   <= ECMPB_RST;
      irq_r     <= 1'b0;
      cma_r     <= 1'b0;
      eov_r     <= 1'b0;
      sir_r     <= 1'b0;
      aw_has_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_has_r   <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'h0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      ctrl_r    <= ctrl_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      period_r  <= period_nxt;
      cmpa_r    <= cmpa_nxt;
      cmpcf_r   <= cmpcf_nxt;
      ecmpa_r   <= ecmpa_nxt;
      ecmpb_r   <= ecmpb_nxt;
      irq_r     <= irq_nxt;
      cma_r     <= cma_nxt;
      eov_r     <= eov_nxt;
      sir_r     <= sir_nxt;
      aw_has_r  <= aw_has_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_has_r   <= w_has_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // outputs straight from flops; pins held disabled
  assign s_awready = !aw_has_r;
  assign s_wready  = !w_has_r;
  assign s_bvalid  = bvalid_r;
  assign s_bresp   = bresp_r;
  assign s_arready = !rvalid_r;
  assign s_rvalid  = rvalid_r;
  assign s_rresp   = rresp_r;
  assign s_rdata   = rdata_r;
  assign conversion_start_trigger = trig_r;
  assign compare_a_irq            = sir_r;
  assign counter_match_a_irq      = cma_r;
  assign counter_overflow_irq     = eov_r;
  assign irq                      = irq_r;
  assign timer_pins.oe_n          = 4'hF;
  assign timer_pins.o             = 4'h0;
  assign counter_output_pin       = 1'b0;
  assign counter_output_pin_oe_n  = 1'b1;

  // ****************************************************
  // checks
  // ****************************************************
  a_period_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_r && counter_value_r == period_r |=> counter_value_r == '0)
    else $error("counter did not clear at period");
  a_trig_match: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_r && counter_value_r == cmpa_r |=> trig_r ##1 stat_r[ST_SAMP_A])
    else $error("compare-A trigger or status missing");
  a_tick_space: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_r |=> !tick_r [*8]) else $error("prescale tick too close");
  a_pins_off: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_pins.oe_n == 4'hF && counter_output_pin_oe_n)
    else $error("timer pin driven");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_r == |(stat_r & mask_r)) else $error("irq level wrong");
  a_trig_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_r |-> $past(tick_r) && $past(counter_value_r) == $past(cmpa_r))
    else $error("trigger without compare-A");
  a_ov_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    e_ov |=> stat_r[ST_EDGE_OV]) else $error("overflow not latched");

endmodule

/* testbench/atc_conv_model.sv */
`timescale 1ns/1ns
// ****************************************************
// converter model fed by the start trigger
// ****************************************************
module atc_conv_model
  import atc_pkg::*;
#(
  parameter int CONV_CYC = 20
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // start trigger from the timer block
  input  wire logic trig,
  // end of conversion line and its flip count
  output logic      eoc,
  output int        n_toggles
);
  int wait_r;

  // conversion takes a fixed time, then flips the end line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_r    <= 0;
      eoc       <= 1'b0;
      n_toggles <= 0;
    end else if (trig) begin
      wait_r <= CONV_CYC;
    end else if (wait_r == 1) begin
      wait_r    <= 0;
      eoc       <= ~eoc;
      n_toggles <= n_toggles + 1;
    end else if (wait_r > 1) begin
      wait_r <= wait_r - 1;
    end
  end
endmodule

/* testbench/test_adc_trigger_timer_and_edge_counter.sv */
`timescale 1ns/1ns
module test_adc_trigger_timer_and_edge_counter;
  import atc_pkg::*;
  logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ext_in, trig;
  logic samp_irq, edge_a_irq, edge_ov_irq, irq, out_pin, out_pin_oe_n;
  atc_pins_t pins;
  int fails, n_tests, cyc, last_t, gap, wide, n_tog;
  logic prev_trig;

  // ****************************************************
  // design, converter model, clock
  // ****************************************************
  atc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .external_count_input(ext_in),
    .conversion_start_trigger(trig), .compare_a_irq(samp_irq),
    .counter_match_a_irq(edge_a_irq), .counter_overflow_irq(edge_ov_irq),
    .irq(irq), .timer_pins(pins), .counter_output_pin(out_pin),
    .counter_output_pin_oe_n(out_pin_oe_n));
  atc_conv_model conv (.aclk(aclk), .aresetn(aresetn), .trig(trig),
    .eoc(ext_in), .n_toggles(n_tog));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // trigger spacing and pulse width monitor
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    prev_trig <= trig;
    if (trig === 1'b1) begin
      gap    <= cyc - last_t;
      last_t <= cyc;
      if (prev_trig === 1'b1) wide <= wide + 1;
    end
  end

  // ****************************************************
  // bus tasks and comparison
  // ****************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok, w_ok;
    int t;
    aw_ok = 0;
    w_ok = 0;
    t = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_ok && w_ok) && t < 200) begin
      @(posedge aclk);
      t++;
      if (!aw_ok && s_awready === 1'b1) begin
        aw_ok = 1;
        s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready === 1'b1) begin
        w_ok = 1;
        s_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      t++;
    end while (s_bvalid !== 1'b1 && t < 400);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    int t;
    t = 0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1 && t < 200);
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
    s_arvalid <= 1'b0;
  endtask

  task automatic wait_trig();
    int t;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
    end while (trig !== 1'b1 && t < 20000);
    #1;
  endtask

  task automatic conclude();
    $display("comparisons %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    conclude();
  end

  // ****************************************************
  // test sequence
  // ****************************************************
  logic [7:0]  r_addr [8] = '{ADDR_CTRL, ADDR_MASK, ADDR_PERIOD, ADDR_CMPA,
                               ADDR_CMPC, ADDR_ECMPA, ADDR_ECMPB, ADDR_PRIO};
  logic [31:0] r_mask [8] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
    32'hFFFFFFFF, 32'h0000FFFF, 32'hFFFFFFFF, 32'h000000FF, 32'hFFFFFFFF};
  logic [31:0] r_exp  [8] = '{32'h3, 32'h7, 32'h80, 32'h80, 32'h68, 32'h80,
                              32'h0A, 32'hAF};
  int          e_n    [6] = '{127, 128, 129, 255, 256, 257};
  logic [7:0]  e_cnt  [6] = '{8'h7F, 8'h80, 8'h81, 8'hFF, 8'h00, 8'h01};
  logic [1:0]  e_st   [6] = '{2'b00, 2'b01, 2'b00, 2'b00, 2'b10, 2'b10};

  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0;
    s_wstrb = 4'h0;
    {fails, n_tests, cyc, last_t, gap, wide} = '0;
    prev_trig = 1'b0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values of the register map
    for (int i = 0; i < 8; i++) begin
      axi_read(r_addr[i]);
      check(rd & r_mask[i], r_exp[i]);
    end
    axi_write(ADDR_PRIO, 32'h0);
    axi_read(ADDR_PRIO);
    check(rd, 32'hAF);
    axi_read(8'h28);
    check(rsp, 2'b10);
    check(rd, 32'h0);
    axi_write(8'h28, 32'h1);
    check(rsp, 2'b10);
    check({pins, out_pin, out_pin_oe_n}, {4'hF, 4'h0, 1'b0, 1'b1});
    // trigger and interrupt on compare-A, period of the cycle
    wait_trig();
    repeat (4) @(posedge aclk);
    #1;
    check({samp_irq, irq}, 2'b11);
    axi_write(ADDR_STATUS, 32'h1);
    repeat (3) @(posedge aclk);
    #1;
    check(irq, 1'b0);
    wait_trig();
    @(posedge aclk);
    #1;
    check(gap, (128 + 1) * PRESCALE);
    axi_write(ADDR_MASK, 32'h6);
    wait_trig();
    repeat (4) @(posedge aclk);
    #1;
    axi_read(ADDR_STATUS);
    check({rd[0], irq, samp_irq}, 3'b100);
    axi_write(ADDR_MASK, 32'h7);
    // shorten the cycle so the converter flips the count pin often
    wait_trig();
    axi_write(ADDR_CMPA, 32'h1);
    axi_write(ADDR_PERIOD, 32'h1);
    axi_write(ADDR_STATUS, 32'h7);
    wait_trig();
    @(posedge aclk);
    #1;
    check(gap, 2 * PRESCALE);
    // edge counter match, free run and wrap
    for (int i = 0; i < 6; i++) begin
      for (int t = 0; t < 40000 && n_tog < e_n[i]; t++) @(posedge aclk);
      repeat (10) @(posedge aclk);
      axi_read(ADDR_COUNT);
      check(rd[23:16], e_cnt[i]);
      axi_read(ADDR_STATUS);
      check(rd & 32'hFFFFFFFE, {29'h0, e_st[i], 1'b0});
      check({edge_ov_irq, edge_a_irq}, e_st[i]);
      if (e_n[i] == 128) axi_write(ADDR_STATUS, 32'h2);
    end
    check(wide, 0);
    conclude();
  end
endmodule
